// *** rtl/hbe_bridge.sv ***
// Host bridge error response, reporting and byte-order control
`timescale 1ns/10ps
`include "hbe_cfg.svh"
module hbe_bridge (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Transfer request
	input wire logic xfer_valid,
	input wire logic xfer_store,
	input wire hbe_pkg::hbe_route_t xfer_route,
	input wire logic [31:0] xfer_addr,
	input wire logic [31:0] xfer_data,
	input wire logic [31:0] xfer_corr_data,
	// Error indications for the transfer
	input wire logic ecc_single,
	input wire logic ecc_double,
	input wire logic bus_timeout,
	input wire logic pci_target_abort,
	input wire logic pci_master_abort,
	// PCI parity and system error pins, active low
	input wire logic pci_perr_n,
	input wire logic pci_serr_n,
	// Transfer completion
	output logic done_ff,
	output logic mem_we_ff,
	output logic pci_we_ff,
	output logic [31:0] out_addr_ff,
	output logic [31:0] out_data_ff,
	// Reports
	output logic irq_out,
	output logic mchk_out
);
	logic [7:0] ctrl_ff;
	logic [7:0] irq_en_ff;
	logic [7:0] mck_en_ff;
	logic [7:0] status_ff;
	logic [7:0] mask_ff;
	logic [1:0] perr_sync_ff;
	logic [1:0] serr_sync_ff;
	logic [7:0] mchk_ff;
	logic [7:0] nxt_status;
	logic [7:0] events;
	logic [31:0] lane_addr;
	logic [31:0] lane_data;
	logic [31:0] sel_data;
	logic big_mode;
	logic drop;
	hbe_pkg::hbe_state_t state_ff;

	function automatic logic [7:0] reg_sel(input logic [3:0] a, input logic [3:0] off);
		reg_sel = (a == off) ? 8'hff : 8'h00;
	endfunction

	assign big_mode = ctrl_ff[`HBE_CTRL_BIG_BIT];

	hbe_lane u_lane (
		.big_mode(big_mode),
		.route(xfer_route),
		.to_pci(xfer_route == hbe_pkg::HBE_ROUTE_TO_PCI),
		.addr_in(xfer_addr),
		.data_in(sel_data),
		.addr_out(lane_addr),
		.data_out(lane_data)
	);

	// Pins from outside the clock domain
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			perr_sync_ff <= 2'h3;
			serr_sync_ff <= 2'h3;
		end else begin
			perr_sync_ff <= {perr_sync_ff[0], pci_perr_n};
			serr_sync_ff <= {serr_sync_ff[0], pci_serr_n};
		end
	end

	// Data chosen before any lane change
	always_comb begin
		sel_data = xfer_data;
		drop = 1'b0;
		if (xfer_store) begin
			if (ecc_single) begin
				sel_data = xfer_corr_data;
			end
			drop = ecc_double | bus_timeout | pci_target_abort | pci_master_abort;
		end else begin
			if (pci_target_abort | pci_master_abort) begin
				sel_data = 32'hffffffff;
			end else if (bus_timeout) begin
				sel_data = 32'h00000000;
			end else if (ecc_single & ~ecc_double) begin
				sel_data = xfer_corr_data;
			end
		end
	end

	// Completion; never stalls the requester
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= hbe_pkg::HBE_ST_IDLE;
			done_ff <= 1'b0;
			mem_we_ff <= 1'b0;
			pci_we_ff <= 1'b0;
			out_addr_ff <= 32'h00000000;
			out_data_ff <= 32'h00000000;
		end else begin
			done_ff <= xfer_valid;
			mem_we_ff <= 1'b0;
			pci_we_ff <= 1'b0;
			unique case (state_ff)
				hbe_pkg::HBE_ST_IDLE: begin
					if (xfer_valid) begin
						state_ff <= hbe_pkg::HBE_ST_DONE;
					end
				end
				hbe_pkg::HBE_ST_DONE: begin
					if (!xfer_valid) begin
						state_ff <= hbe_pkg::HBE_ST_IDLE;
					end
				end
			endcase
			if (xfer_valid) begin
				out_addr_ff <= lane_addr;
				out_data_ff <= lane_data;
				mem_we_ff <= xfer_store & ~drop & (xfer_route != hbe_pkg::HBE_ROUTE_TO_PCI);
				pci_we_ff <= xfer_store & ~drop & (xfer_route == hbe_pkg::HBE_ROUTE_TO_PCI);
			end
		end
	end

	// parity and system errors only report
	always_comb begin
		events = 8'h00;
		events[hbe_pkg::HBE_ERR_ECC1] = xfer_valid & ecc_single & ~ecc_double;
		events[hbe_pkg::HBE_ERR_ECC2] = xfer_valid & ecc_double;
		events[hbe_pkg::HBE_ERR_TMO] = xfer_valid & bus_timeout;
		events[hbe_pkg::HBE_ERR_TABT] = xfer_valid & pci_target_abort;
		events[hbe_pkg::HBE_ERR_MABT] = xfer_valid & pci_master_abort;
		events[hbe_pkg::HBE_ERR_PERR] = ~perr_sync_ff[1];
		events[hbe_pkg::HBE_ERR_SERR] = ~serr_sync_ff[1];
	end

	// Sticky status; set beats write-one clear
	always_comb begin
		nxt_status = status_ff;
		if (reg_wr && reg_addr == `HBE_OFF_STATUS) begin
			nxt_status = status_ff & ~reg_wdata[7:0];
		end
		nxt_status = nxt_status | (events & irq_en_ff);
	end

	// Control registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= `HBE_RST_CTRL;
			irq_en_ff <= `HBE_RST_EN;
			mck_en_ff <= `HBE_RST_EN;
			mask_ff <= `HBE_RST_EN;
		end else if (reg_wr) begin
			if (reg_addr == `HBE_OFF_CTRL) ctrl_ff <= reg_wdata[7:0];
			if (reg_addr == `HBE_OFF_IRQ_EN) irq_en_ff <= reg_wdata[7:0];
			if (reg_addr == `HBE_OFF_MCK_EN) mck_en_ff <= reg_wdata[7:0];
			if (reg_addr == `HBE_OFF_MASK) mask_ff <= reg_wdata[7:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_ff <= 8'h00;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// machine-check sticky until write-one clear, never one-bit ECC
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mchk_ff <= 8'h00;
		end else begin
			mchk_ff <= (mchk_ff & ~((reg_wr && reg_addr == `HBE_OFF_STATUS) ?
				reg_wdata[7:0] : 8'h00)) |
				(events & mck_en_ff & `HBE_MCK_CAPABLE);
		end
	end

	assign irq_out = |(status_ff & mask_ff);
	assign mchk_out = |mchk_ff;

	// Read port, unmapped reads zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= {24'h000000,
				(reg_sel(reg_addr, `HBE_OFF_CTRL) & ctrl_ff) |
				(reg_sel(reg_addr, `HBE_OFF_IRQ_EN) & irq_en_ff) |
				(reg_sel(reg_addr, `HBE_OFF_MCK_EN) & mck_en_ff) |
				(reg_sel(reg_addr, `HBE_OFF_STATUS) & status_ff) |
				(reg_sel(reg_addr, `HBE_OFF_MASK) & mask_ff)};
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// one-bit ECC alone never raises machine-check
	chk_ecc1_no_mchk: assert property (@(posedge clk) disable iff (rst)
		(events == 8'h01 && mchk_ff == 8'h00) |=> !mchk_out)
		else $error("machine check from single-bit ECC");
	chk_mchk_enabled: assert property (@(posedge clk) disable iff (rst)
		(events[1] && mck_en_ff[1]) |=> mchk_out)
		else $error("double-bit ECC missed machine check");
	chk_irq_gated: assert property (@(posedge clk) disable iff (rst)
		(events[2] && !irq_en_ff[2] && !status_ff[2]) |=> !status_ff[2])
		else $error("disabled class latched status");
	chk_irq_sticky: assert property (@(posedge clk) disable iff (rst)
		(status_ff[1] && mask_ff[1] && !reg_wr) |=> irq_out)
		else $error("interrupt dropped while status set");
	chk_store_drop: assert property (@(posedge clk) disable iff (rst)
		(xfer_valid && xfer_store && (bus_timeout || pci_master_abort)) |=>
		(!mem_we_ff && !pci_we_ff && done_ff))
		else $error("faulted store was written");
	chk_ecc2_store: assert property (@(posedge clk) disable iff (rst)
		(xfer_valid && xfer_store && ecc_double) |=> (done_ff && !mem_we_ff))
		else $error("double-bit store reached memory");
	chk_abort_ones: assert property (@(posedge clk) disable iff (rst)
		(xfer_valid && !xfer_store && pci_target_abort) |=>
		(out_data_ff == 32'hffffffff))
		else $error("abort load not all ones");
	chk_ecc1_store: assert property (@(posedge clk) disable iff (rst)
		(xfer_valid && xfer_store && ecc_single && !ecc_double && !bus_timeout &&
		!pci_target_abort && !pci_master_abort && xfer_route == hbe_pkg::HBE_ROUTE_LOCAL) |=>
		(mem_we_ff && out_data_ff == $past(xfer_corr_data)))
		else $error("corrected store data not written");
	chk_little_noswap: assert property (@(posedge clk) disable iff (rst)
		(xfer_valid && !big_mode && !xfer_store && !ecc_single &&
		!bus_timeout && !pci_target_abort && !pci_master_abort) |=>
		(out_data_ff == $past(xfer_data)))
		else $error("little-endian data lanes changed");
endmodule

// *** rtl/hbe_cfg.svh ***
// Offsets, field positions and reset values of the host bridge error/endian block
`ifndef HBE_CFG_SVH
`define HBE_CFG_SVH
`define HBE_OFF_CTRL 4'h0
`define HBE_OFF_IRQ_EN 4'h1
`define HBE_OFF_MCK_EN 4'h2
`define HBE_OFF_STATUS 4'h3
`define HBE_OFF_MASK 4'h4
`define HBE_CTRL_BIG_BIT 0
`define HBE_RST_CTRL 8'h01
`define HBE_RST_EN 8'h00
`define HBE_NUM_ERR 7
`define HBE_MCK_CAPABLE 8'h7e
`endif

// *** rtl/hbe_pkg.sv ***
// Types of the host bridge error/endian block
package hbe_pkg;
	typedef enum logic [2:0] {
		HBE_ERR_ECC1,
		HBE_ERR_ECC2,
		HBE_ERR_TMO,
		HBE_ERR_TABT,
		HBE_ERR_MABT,
		HBE_ERR_PERR,
		HBE_ERR_SERR
	} hbe_err_t;
	typedef enum logic [1:0] {
		HBE_ROUTE_LOCAL,
		HBE_ROUTE_TO_PCI,
		HBE_ROUTE_FROM_PCI
	} hbe_route_t;
	typedef enum logic {
		HBE_ST_IDLE,
		HBE_ST_DONE
	} hbe_state_t;
endpackage

// *** rtl/hbe_lane.sv ***
// Byte lane swap and address rearrangement for one transfer
`timescale 1ns/10ps
module hbe_lane (
	// Mode and route
	input wire logic big_mode,
	input wire hbe_pkg::hbe_route_t route,
	input wire logic to_pci,
	// Transfer
	input wire logic [31:0] addr_in,
	input wire logic [31:0] data_in,
	output logic [31:0] addr_out,
	output logic [31:0] data_out
);
	function automatic logic [31:0] swap32(input logic [31:0] d);
		swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction
	always_comb begin
		addr_out = addr_in;
		data_out = data_in;
		if (route != hbe_pkg::HBE_ROUTE_LOCAL) begin
			if (big_mode) begin
				data_out = swap32(data_in);
			end else begin
				addr_out = {addr_in[31:3], addr_in[2:0] ^ 3'h7};
			end
		end
	end
	wire unused_dir = to_pci;
endmodule

// *** tb/hbe_far_model.sv ***
// Far-side memory and PCI agent model for the host bridge
`timescale 1ns/10ps
module hbe_far_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Strobes and word from the bridge
	input wire logic mem_we,
	input wire logic pci_we,
	input wire logic [31:0] wr_data,
	// Error pin requests from the bench
	input wire logic perr_req,
	input wire logic serr_req,
	// Pins and observations
	output logic pci_perr_n_ff,
	output logic pci_serr_n_ff,
	output logic [7:0] mem_cnt_ff,
	output logic [7:0] pci_cnt_ff,
	output logic [31:0] pci_word_ff
);
	// word kept as wired, lane 0 lowest byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_cnt_ff <= 8'h00;
			pci_cnt_ff <= 8'h00;
			pci_word_ff <= 32'h00000000;
		end else begin
			mem_cnt_ff <= mem_cnt_ff + {7'h00, mem_we};
			pci_cnt_ff <= pci_cnt_ff + {7'h00, pci_we};
			if (pci_we) begin
				pci_word_ff <= wr_data;
			end
		end
	end
	// Pins pulled up, low only while the bench asks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pci_perr_n_ff <= 1'b1;
			pci_serr_n_ff <= 1'b1;
		end else begin
			pci_perr_n_ff <= ~perr_req;
			pci_serr_n_ff <= ~serr_req;
		end
	end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the host bridge error and byte-order block
`timescale 1ns/10ps
`include "hbe_cfg.svh"
module tb_top;
	localparam hbe_pkg::hbe_route_t rt_lo = hbe_pkg::HBE_ROUTE_LOCAL;
	localparam hbe_pkg::hbe_route_t rt_tp = hbe_pkg::HBE_ROUTE_TO_PCI;
	localparam hbe_pkg::hbe_route_t rt_fp = hbe_pkg::HBE_ROUTE_FROM_PCI;
	localparam logic [31:0] a0 = 32'h00001000, d0 = 32'h11223344, ds0 = 32'h44332211;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, xfer_addr = 32'h0, xfer_data = 32'h0, xfer_corr_data = 32'h0;
	logic xfer_valid = 1'b0, xfer_store = 1'b0, perr_req = 1'b0, serr_req = 1'b0;
	hbe_pkg::hbe_route_t xfer_route = hbe_pkg::HBE_ROUTE_LOCAL;
	logic [4:0] err = 5'h00;
	logic pci_perr_n, pci_serr_n, done_ff, mem_we_ff, pci_we_ff, irq_out, mchk_out;
	logic [31:0] reg_rdata, out_addr_ff, out_data_ff, pci_word_ff;
	logic [7:0] mem_cnt_ff, pci_cnt_ff;
	int n_mismatch = 0, cmp_count = 0;
	always #2 clk = ~clk;
	hbe_bridge i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_valid(xfer_valid),
		.xfer_store(xfer_store), .xfer_route(xfer_route), .xfer_addr(xfer_addr),
		.xfer_data(xfer_data), .xfer_corr_data(xfer_corr_data), .ecc_single(err[0]),
		.ecc_double(err[1]), .bus_timeout(err[2]), .pci_target_abort(err[3]),
		.pci_master_abort(err[4]), .pci_perr_n(pci_perr_n), .pci_serr_n(pci_serr_n),
		.done_ff(done_ff), .mem_we_ff(mem_we_ff), .pci_we_ff(pci_we_ff),
		.out_addr_ff(out_addr_ff), .out_data_ff(out_data_ff), .irq_out(irq_out),
		.mchk_out(mchk_out));
	hbe_far_model i_far (.clk(clk), .rst(rst), .mem_we(mem_we_ff), .pci_we(pci_we_ff),
		.wr_data(out_data_ff), .perr_req(perr_req), .serr_req(serr_req),
		.pci_perr_n_ff(pci_perr_n), .pci_serr_n_ff(pci_serr_n), .mem_cnt_ff(mem_cnt_ff),
		.pci_cnt_ff(pci_cnt_ff), .pci_word_ff(pci_word_ff));
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// Raw word d0, corrected word its inverse, so the two never match
	task automatic xf(input logic st, input hbe_pkg::hbe_route_t rt, input logic [4:0] e,
		input logic [1:0] we, input logic [31:0] ea, input logic [31:0] ed);
		@(posedge clk);
		xfer_valid <= 1'b1;
		xfer_store <= st;
		xfer_route <= rt;
		xfer_addr <= a0;
		xfer_data <= d0;
		xfer_corr_data <= ~d0;
		err <= e;
		@(posedge clk);
		xfer_valid <= 1'b0;
		err <= 5'h00;
		#1 chk({29'h0, done_ff, mem_we_ff, pci_we_ff}, {29'h0, 1'b1, we});
		if (!st || we != 2'b00) begin
			chk(out_addr_ff, ea);
			chk(out_data_ff, ed);
		end
	endtask
	initial begin
		#20000;
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(`HBE_OFF_CTRL, 32'h1);
		rd(`HBE_OFF_IRQ_EN, 32'h0);
		rd(`HBE_OFF_MCK_EN, 32'h0);
		rd(`HBE_OFF_MASK, 32'h0);
		wr(4'hf, 32'hffffffff);
		rd(4'hf, 32'h0);
		$display("test reset values done");
		xf(1'b1, rt_lo, 5'h00, 2'b10, a0, d0);
		xf(1'b1, rt_tp, 5'h00, 2'b01, a0, ds0);
		xf(1'b0, rt_fp, 5'h00, 2'b00, a0, ds0);
		xf(1'b1, rt_fp, 5'h00, 2'b10, a0, ds0);
		// processor side already presents little-endian words
		wr(`HBE_OFF_CTRL, 32'h0);
		xf(1'b1, rt_tp, 5'h00, 2'b01, a0 ^ 32'h7, d0);
		xf(1'b1, rt_fp, 5'h00, 2'b10, a0 ^ 32'h7, d0);
		xf(1'b0, rt_fp, 5'h00, 2'b00, a0 ^ 32'h7, d0);
		xf(1'b1, rt_lo, 5'h00, 2'b10, a0, d0);
		chk(pci_word_ff, d0);
		wr(`HBE_OFF_CTRL, 32'h1);
		$display("test byte order done");
		xf(1'b1, rt_lo, 5'h01, 2'b10, a0, ~d0);
		xf(1'b0, rt_lo, 5'h01, 2'b00, a0, ~d0);
		xf(1'b1, rt_lo, 5'h02, 2'b00, a0, d0);
		xf(1'b0, rt_lo, 5'h02, 2'b00, a0, d0);
		xf(1'b0, rt_tp, 5'h04, 2'b00, a0, 32'h0);
		for (int i = 2; i < 5; i++) begin
			xf(1'b1, rt_tp, 5'h01 << i, 2'b00, a0, d0);
		end
		for (int i = 3; i < 5; i++) begin
			xf(1'b0, rt_tp, (5'h01 << i) | 5'h04, 2'b00, a0, 32'hffffffff);
		end
		chk({16'h0000, mem_cnt_ff, pci_cnt_ff}, 32'h0502);
		rd(`HBE_OFF_STATUS, 32'h0);
		$display("test error actions done");
		wr(`HBE_OFF_IRQ_EN, 32'h7f);
		wr(`HBE_OFF_MCK_EN, 32'h7f);
		// A set mask bit lets its status bit through
		wr(`HBE_OFF_MASK, 32'h7f);
		xf(1'b0, rt_lo, 5'h01, 2'b00, a0, ~d0);
		rd(`HBE_OFF_STATUS, 32'h1);
		chk({30'h0, irq_out, mchk_out}, 32'h2);
		wr(`HBE_OFF_STATUS, 32'h1);
		xf(1'b0, rt_lo, 5'h02, 2'b00, a0, d0);
		rd(`HBE_OFF_STATUS, 32'h2);
		chk({30'h0, irq_out, mchk_out}, 32'h3);
		wr(`HBE_OFF_MASK, 32'h7d);
		chk({30'h0, irq_out, mchk_out}, 32'h1);
		wr(`HBE_OFF_STATUS, 32'h2);
		chk({30'h0, irq_out, mchk_out}, 32'h0);
		wr(`HBE_OFF_MASK, 32'h7f);
		$display("test reports done");
		for (int j = 5; j < 7; j++) begin
			@(posedge clk);
			perr_req <= (j == 5);
			serr_req <= (j == 6);
			@(posedge clk);
			perr_req <= 1'b0;
			serr_req <= 1'b0;
			repeat (4) @(posedge clk);
			rd(`HBE_OFF_STATUS, 32'h1 << j);
			chk({30'h0, irq_out, mchk_out}, 32'h3);
			wr(`HBE_OFF_STATUS, 32'h1 << j);
		end
		chk({16'h0000, mem_cnt_ff, pci_cnt_ff}, 32'h0502);
		$display("test pci pins done");
		report_and_stop;
	end
endmodule
